// [rtl/clock_system.sv]
// Clock source decode, start-up timing, divider register and domain gating
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module clock_system #(
    parameter int WAKE_16K_CYC = clk_sel_pkg::WAKE_16K,
    parameter int WAKE_32K_CYC = clk_sel_pkg::WAKE_32K,
    parameter int WDT_SHORT_CYC = clk_sel_pkg::WDT_4K,
    parameter int WDT_LONG_CYC = clk_sel_pkg::WDT_64K
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire clk_sel_pkg::wb_req_t wb_req,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire clk_sel_pkg::fuse_t fuse_pins,
    input wire logic wdt_osc_pin,
    input wire logic async_xtal_pin,
    input wire clk_sel_pkg::sleep_t sleep_mode,
    input wire logic wake_req,
    output clk_sel_pkg::domain_en_t domain_en,
    output logic async_detect_en,
    output logic core_run,
    output logic amp_full_swing,
    output clk_sel_pkg::xtal_range_t xtal_range
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level counts once stages two and three agree
    logic [2:0] wdt_sync_q;
    logic [2:0] xtal_sync_q;
    logic wdt_lvl_q;
    logic xtal_lvl_q;
    clk_sel_pkg::fuse_t fuse_s1_q;
    clk_sel_pkg::fuse_t fuse_s2_q;
    clk_sel_pkg::fuse_t fuse_s3_q;

    wire logic wdt_agree = (wdt_sync_q[1] == wdt_sync_q[2]);
    wire logic xtal_agree = (xtal_sync_q[1] == xtal_sync_q[2]);
    wire logic wdt_rise = wdt_agree & wdt_sync_q[2] & ~wdt_lvl_q;
    wire logic fuse_stable = (fuse_s2_q == fuse_s3_q);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wdt_sync_q <= 3'h0;
            xtal_sync_q <= 3'h0;
            wdt_lvl_q <= 1'b0;
            xtal_lvl_q <= 1'b0;
            fuse_s1_q <= clk_sel_pkg::FUSE_SHIPPED;
            fuse_s2_q <= clk_sel_pkg::FUSE_SHIPPED;
            fuse_s3_q <= clk_sel_pkg::FUSE_SHIPPED;
        end else begin
            wdt_sync_q <= {wdt_sync_q[1:0], wdt_osc_pin};
            xtal_sync_q <= {xtal_sync_q[1:0], async_xtal_pin};
            wdt_lvl_q <= wdt_agree ? wdt_sync_q[2] : wdt_lvl_q;
            xtal_lvl_q <= xtal_agree ? xtal_sync_q[2] : xtal_lvl_q;
            fuse_s1_q <= fuse_pins;
            fuse_s2_q <= fuse_s1_q;
            fuse_s3_q <= fuse_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fuse decode
    clk_sel_pkg::fuse_t fuse_q;

    function automatic clk_sel_pkg::startup_t decode(input clk_sel_pkg::fuse_t f);
        logic [3:0] cs;
        logic [2:0] key;
        clk_sel_pkg::startup_t r;
        cs = f.clock_source_fuse_select;
        key = {cs[0], f.startup_time_fuse_select};
        r.src = clk_sel_pkg::SRC_EXT_CLK;
        r.wake_cyc = 17'(clk_sel_pkg::WAKE_6);
        r.rst_dly = clk_sel_pkg::RST_DLY_LONG;
        if (cs >= clk_sel_pkg::CS_XTAL_MIN) begin
            r.src = clk_sel_pkg::SRC_XTAL;
            case (key)
                3'h0: begin
                    r.wake_cyc = 17'(clk_sel_pkg::WAKE_258);
                    r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
                end
                3'h1: r.wake_cyc = 17'(clk_sel_pkg::WAKE_258);
                3'h2: begin
                    r.wake_cyc = 17'(clk_sel_pkg::WAKE_1K);
                    r.rst_dly = clk_sel_pkg::RST_DLY_NONE;
                end
                3'h3: begin
                    r.wake_cyc = 17'(clk_sel_pkg::WAKE_1K);
                    r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
                end
                3'h4: r.wake_cyc = 17'(clk_sel_pkg::WAKE_1K);
                3'h5: begin
                    r.wake_cyc = 17'(WAKE_16K_CYC);
                    r.rst_dly = clk_sel_pkg::RST_DLY_NONE;
                end
                3'h6: begin
                    r.wake_cyc = 17'(WAKE_16K_CYC);
                    r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
                end
                default: r.wake_cyc = 17'(WAKE_16K_CYC);
            endcase
        end else if (cs == clk_sel_pkg::CS_LF_XTAL) begin
            r.src = clk_sel_pkg::SRC_LF_XTAL;
            case (f.startup_time_fuse_select)
                2'h0: begin
                    r.wake_cyc = 17'(clk_sel_pkg::WAKE_1K);
                    r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
                end
                2'h1: r.wake_cyc = 17'(clk_sel_pkg::WAKE_1K);
                default: r.wake_cyc = 17'(WAKE_32K_CYC);
            endcase
        end else if (cs >= clk_sel_pkg::CS_EXT_RC_MIN) begin
            r.src = clk_sel_pkg::SRC_EXT_RC;
            case (f.startup_time_fuse_select)
                2'h0: begin
                    r.wake_cyc = 17'(clk_sel_pkg::WAKE_18);
                    r.rst_dly = clk_sel_pkg::RST_DLY_NONE;
                end
                2'h1: begin
                    r.wake_cyc = 17'(clk_sel_pkg::WAKE_18);
                    r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
                end
                2'h2: r.wake_cyc = 17'(clk_sel_pkg::WAKE_18);
                default: r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
            endcase
        end else begin
            // Internal RC and external clock share the short start-up table
            if (cs >= clk_sel_pkg::CS_INT_RC_MIN) begin
                r.src = clk_sel_pkg::SRC_INT_RC;
            end
            case (f.startup_time_fuse_select)
                2'h0: r.rst_dly = clk_sel_pkg::RST_DLY_NONE;
                2'h1: r.rst_dly = clk_sel_pkg::RST_DLY_SHORT;
                default: r.rst_dly = clk_sel_pkg::RST_DLY_LONG;
            endcase
        end
        return r;
    endfunction : decode

    wire clk_sel_pkg::startup_t dec = decode(fuse_q);
    wire logic [2:0] range_code = fuse_q.clock_source_fuse_select[3:1];
    // Stored zero means programmed, so the option is active when the bit reads zero
    wire logic amp_programmed = ~fuse_q.oscillator_amp_option_fuse;
    wire clk_sel_pkg::xtal_range_t range_d =
        amp_programmed ? clk_sel_pkg::RNG_WIDE :
        (range_code == clk_sel_pkg::RANGE_LOW) ? clk_sel_pkg::RNG_LOW :
        (range_code == clk_sel_pkg::RANGE_MID) ? clk_sel_pkg::RNG_MID : clk_sel_pkg::RNG_HIGH;
    wire logic [16:0] wdt_target = (dec.rst_dly == clk_sel_pkg::RST_DLY_LONG) ?
        17'(WDT_LONG_CYC) : 17'(WDT_SHORT_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Start-up sequencer
    clk_sel_pkg::startup_state_t state_q;
    clk_sel_pkg::startup_state_t state_d;
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    logic [1:0] fill_q;

    wire logic fuse_ready = (fill_q == 2'(clk_sel_pkg::FUSE_SYNC_WAIT)) & fuse_stable;
    wire logic deep_sleep = (sleep_mode == clk_sel_pkg::SLP_POWER_DOWN) |
                            (sleep_mode == clk_sel_pkg::SLP_POWER_SAVE);
    wire logic [16:0] cnt_inc = 17'(cnt_q + 17'h00001);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            clk_sel_pkg::ST_FUSE: begin
                cnt_d = 17'h00000;
                if (fuse_ready) begin
                    state_d = clk_sel_pkg::ST_RESET_DLY;
                end
            end
            clk_sel_pkg::ST_RESET_DLY: begin
                if (dec.rst_dly == clk_sel_pkg::RST_DLY_NONE) begin
                    state_d = clk_sel_pkg::ST_WAKE;
                end else if (wdt_rise) begin
                    cnt_d = cnt_inc;
                    if (cnt_inc == wdt_target) begin
                        state_d = clk_sel_pkg::ST_WAKE;
                        cnt_d = 17'h00000;
                    end
                end
            end
            clk_sel_pkg::ST_WAKE: begin
                // Source clock is mclk, so start-up counts plain cycles
                cnt_d = cnt_inc;
                if (cnt_inc == dec.wake_cyc) begin
                    state_d = clk_sel_pkg::ST_RUN;
                    cnt_d = 17'h00000;
                end
            end
            clk_sel_pkg::ST_RUN: begin
                if (wake_req & deep_sleep) begin
                    state_d = clk_sel_pkg::ST_WAKE;
                    cnt_d = 17'h00000;
                end
            end
            default: begin
                state_d = clk_sel_pkg::ST_FUSE;
                cnt_d = 17'h00000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= clk_sel_pkg::ST_FUSE;
            cnt_q <= 17'h00000;
            fill_q <= 2'h0;
            fuse_q <= clk_sel_pkg::FUSE_SHIPPED;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            // Saturate, so a late fuse change cannot wrap the wait back to zero
            fill_q <= (fill_q == 2'(clk_sel_pkg::FUSE_SYNC_WAIT)) ? fill_q : 2'(fill_q + 2'h1);
            // Fuses sampled once after release, never during reset
            if (state_q == clk_sel_pkg::ST_FUSE && fuse_ready) begin
                fuse_q <= fuse_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider register on the bus
    logic div_en_q;
    logic [6:0] div_val_q;
    logic ack_q;
    logic [31:0] dat_q;

    wire logic wb_hit = wb_req.cyc & wb_req.stb & ~ack_q;
    wire logic sel_div = (wb_req.adr == clk_sel_pkg::REG_DIV_OFS);
    wire logic sel_status = (wb_req.adr == clk_sel_pkg::REG_STATUS_OFS);
    wire logic sel_fuse = (wb_req.adr == clk_sel_pkg::REG_FUSE_OFS);
    wire logic wr_div = wb_hit & wb_req.we & wb_req.sel[0] & sel_div;
    wire logic wr_en_bit = wb_req.dat[clk_sel_pkg::DIV_EN_BIT];
    // Value only taken on the zero-to-one edge of the enable
    wire logic accept_val = wr_div & wr_en_bit & ~div_en_q;
    wire logic [7:0] div_rd = {div_en_q, div_val_q};
    wire logic [31:0] status_rd = (32'(dec.src) << clk_sel_pkg::ST_SRC_POS) |
        (32'(state_q) << clk_sel_pkg::ST_STATE_POS) |
        (32'(amp_programmed) << clk_sel_pkg::ST_AMP_POS) |
        (32'(range_d) << clk_sel_pkg::ST_RANGE_POS) |
        (32'(state_q == clk_sel_pkg::ST_RUN) << clk_sel_pkg::ST_RUN_POS);
    wire logic [31:0] rd_mux = sel_div ? {24'h000000, div_rd} :
                               sel_status ? status_rd :
                               sel_fuse ? {25'h0000000, fuse_q} : 32'h00000000;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            div_en_q <= clk_sel_pkg::DIV_RESET[clk_sel_pkg::DIV_EN_BIT];
            div_val_q <= clk_sel_pkg::DIV_RESET[6:0];
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_hit;
            dat_q <= wb_hit ? rd_mux : 32'h00000000;
            if (wr_div) begin
                div_en_q <= wr_en_bit;
            end
            if (accept_val) begin
                div_val_q <= wb_req.dat[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider and domain gating
    wire logic [7:0] div_factor = div_en_q ?
        8'(clk_sel_pkg::DIV_BASE - int'(div_val_q)) : 8'h01;
    logic div_tick;

    clk_divider u_div (
        .mclk(mclk),
        .rst_b(rst_b),
        .factor(div_factor),
        .tick(div_tick)
    );

    wire logic running = (state_q == clk_sel_pkg::ST_RUN);
    wire logic stop_core = (sleep_mode != clk_sel_pkg::SLP_ACTIVE);
    wire logic stop_io = deep_sleep | (sleep_mode == clk_sel_pkg::SLP_ADC_NR);
    // Crystal domain only stops in power-down; it keeps time in power-save
    wire logic stop_async = (sleep_mode == clk_sel_pkg::SLP_POWER_DOWN);
    clk_sel_pkg::domain_en_t dom_d;
    clk_sel_pkg::domain_en_t dom_q;
    logic detect_q;
    logic run_q;
    logic amp_q;
    clk_sel_pkg::xtal_range_t range_q;

    assign dom_d.core_clock_domain = div_tick & running & ~stop_core;
    assign dom_d.program_memory_clock = div_tick & running & ~stop_core;
    assign dom_d.peripheral_clock_domain = div_tick & running & ~stop_io;
    assign dom_d.converter_clock = div_tick & running & ~deep_sleep;
    assign dom_d.async_timer_clock = xtal_lvl_q & ~stop_async;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            dom_q <= '0;
            detect_q <= 1'b0;
            run_q <= 1'b0;
            amp_q <= 1'b0;
            range_q <= clk_sel_pkg::RNG_LOW;
        end else begin
            dom_q <= dom_d;
            detect_q <= 1'b1;
            run_q <= running;
            amp_q <= amp_programmed;
            range_q <= range_d;
        end
    end

    assign domain_en = dom_q;
    assign async_detect_en = detect_q;
    assign core_run = run_q;
    assign amp_full_swing = amp_q;
    assign xtal_range = range_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    div_accept_a: assert property (accept_val |=> div_val_q == $past(wb_req.dat[6:0]))
        else $error("division value not taken");
    div_reject_a: assert property (wr_div && !wr_en_bit |=> $stable(div_val_q))
        else $error("division value not discarded");
    div_enable_a: assert property (wr_div |=> div_en_q == $past(wr_en_bit))
        else $error("divide enable not stored");
    div_factor_a: assert property (div_en_q |->
        div_factor == 8'(8'h81 - {1'b0, div_val_q}))
        else $error("division factor wrong");
    core_hold_a: assert property (!running |=> !domain_en.core_clock_domain)
        else $error("core clock while held");
    flash_core_a: assert property (
        domain_en.program_memory_clock == domain_en.core_clock_domain)
        else $error("flash and core clocks differ");
    adc_noise_a: assert property (sleep_mode == clk_sel_pkg::SLP_ADC_NR |=>
        !domain_en.peripheral_clock_domain && !domain_en.core_clock_domain)
        else $error("digital clock runs in noise reduction");
    adc_keeps_a: assert property (div_tick && running && !deep_sleep |=>
        domain_en.converter_clock)
        else $error("converter clock stopped");
    lf_decode_a: assert property (
        fuse_q.clock_source_fuse_select == clk_sel_pkg::CS_LF_XTAL |->
        dec.src == clk_sel_pkg::SRC_LF_XTAL)
        else $error("low-frequency crystal not decoded");
    amp_mode_a: assert property (
        ##1 amp_full_swing == !$past(fuse_q.oscillator_amp_option_fuse))
        else $error("amplifier mode inverted");
    detect_on_a: assert property ($past(rst_b) |-> async_detect_en)
        else $error("async detection disabled");
    reset_wait_a: assert property (state_q == clk_sel_pkg::ST_RESET_DLY && !wdt_rise &&
        dec.rst_dly != clk_sel_pkg::RST_DLY_NONE |=> state_q == clk_sel_pkg::ST_RESET_DLY)
        else $error("reset delay left early");

    cover property (state_q == clk_sel_pkg::ST_WAKE ##1 state_q == clk_sel_pkg::ST_RUN);
    cover property (accept_val);
    cover property (sleep_mode == clk_sel_pkg::SLP_ADC_NR && domain_en.converter_clock);

endmodule : clock_system

// [rtl/clk_sel_pkg.sv]
// Constants and types for the system clock select and divider
package clk_sel_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] REG_DIV_OFS = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_FUSE_OFS = 8'h08;
    localparam int DIV_EN_BIT = 7;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam int DIV_BASE = 129;
    localparam int ST_SRC_POS = 0;
    localparam int ST_STATE_POS = 3;
    localparam int ST_AMP_POS = 5;
    localparam int ST_RANGE_POS = 6;
    localparam int ST_RUN_POS = 8;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] CS_XTAL_MIN = 4'ha;
    localparam logic [3:0] CS_LF_XTAL = 4'h9;
    localparam logic [3:0] CS_EXT_RC_MIN = 4'h5;
    localparam logic [3:0] CS_INT_RC_MIN = 4'h1;
    localparam logic [2:0] RANGE_LOW = 3'h5;
    localparam logic [2:0] RANGE_MID = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int WAKE_6 = 6;
    localparam int WAKE_18 = 18;
    localparam int WAKE_258 = 258;
    localparam int WAKE_1K = 1024;
    localparam int WAKE_16K = 16384;
    localparam int WAKE_32K = 32768;
    localparam int WDT_4K = 4096;
    localparam int WDT_64K = 65536;
    localparam int FUSE_SYNC_WAIT = 3;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {SRC_XTAL, SRC_LF_XTAL, SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLK} clk_src_t;
    typedef enum logic [2:0] {
        SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR, SLP_POWER_DOWN, SLP_POWER_SAVE
    } sleep_t;
    typedef enum logic [1:0] {RST_DLY_NONE, RST_DLY_SHORT, RST_DLY_LONG} rst_dly_t;
    typedef enum logic [1:0] {ST_FUSE, ST_RESET_DLY, ST_WAKE, ST_RUN} startup_state_t;
    typedef enum logic [1:0] {RNG_LOW, RNG_MID, RNG_HIGH, RNG_WIDE} xtal_range_t;

    typedef struct packed {
        logic oscillator_amp_option_fuse;
        logic [1:0] startup_time_fuse_select;
        logic [3:0] clock_source_fuse_select;
    } fuse_t;

    localparam fuse_t FUSE_SHIPPED = '{
        oscillator_amp_option_fuse: 1'b1,
        startup_time_fuse_select: 2'h2,
        clock_source_fuse_select: 4'h1
    };

    typedef struct packed {
        logic core_clock_domain;
        logic peripheral_clock_domain;
        logic program_memory_clock;
        logic converter_clock;
        logic async_timer_clock;
    } domain_en_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        clk_src_t src;
        logic [16:0] wake_cyc;
        rst_dly_t rst_dly;
    } startup_t;

endpackage : clk_sel_pkg

// [rtl/clk_divider.sv]
// Glitch-free source clock divider producing one-cycle tick pulses
`timescale 1ns/1ps
module clk_divider (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] factor,
    output logic tick
);

    logic [7:0] cnt_q;
    logic [7:0] cur_q;
    logic tick_q;

    // New factor only taken at a period boundary, so no period is ever cut short
    wire logic at_end = (cnt_q == 8'(cur_q - 8'h01));

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
            cur_q <= 8'h01;
            tick_q <= 1'b0;
        end else if (at_end) begin
            cnt_q <= 8'h00;
            cur_q <= factor;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= 8'(cnt_q + 8'h01);
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;

    ////////////////////////////////////////////////////////////////////////////////
    tick_undivided_a: assert property (@(posedge mclk) disable iff (!rst_b)
        tick_q && cur_q == 8'h01 |=> tick_q)
        else $error("undivided tick missing");

    tick_half_a: assert property (@(posedge mclk) disable iff (!rst_b)
        tick_q && cur_q == 8'h02 |=> !tick_q ##1 tick_q)
        else $error("divide-by-two period wrong");

    cover property (@(posedge mclk) disable iff (!rst_b) tick_q && cur_q != $past(cur_q));

endmodule : clk_divider

// [sim/tb.sv]
// Self-checking bench for the clock select and divider block
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    clk_sel_pkg::wb_req_t req = '0;
    logic ack;
    logic [31:0] rd;
    clk_sel_pkg::fuse_t fuse = clk_sel_pkg::FUSE_SHIPPED;
    logic wdt = 1'b0;
    logic xtal = 1'b0;
    clk_sel_pkg::sleep_t slp = clk_sel_pkg::SLP_ACTIVE;
    logic wake = 1'b0;
    clk_sel_pkg::domain_en_t den;
    logic adet;
    logic run;
    logic amp;
    clk_sel_pkg::xtal_range_t rng;
    int fails = 0;
    int n_checks = 0;
    int pc[5];
    int t;
    logic [31:0] q;
    ////////////////////////////////////////////////////////////////////////////////
    always #5 mclk = ~mclk;
    // Watchdog slower than the sync, or stages two and three never agree
    always begin
        repeat (2) @(posedge mclk);
        wdt <= ~wdt;
    end
    // Crystal well below a quarter of the divided clock
    always begin
        repeat (32) @(posedge mclk);
        xtal <= ~xtal;
    end
    // Short start-up counts keep the sixteen fuse resets cheap
    clock_system #(.WAKE_16K_CYC(20), .WAKE_32K_CYC(30), .WDT_SHORT_CYC(4),
        .WDT_LONG_CYC(8)) dut (.mclk(mclk), .rst_b(rst_b), .wb_req(req), .wb_ack_o(ack),
        .wb_dat_o(rd), .fuse_pins(fuse), .wdt_osc_pin(wdt), .async_xtal_pin(xtal),
        .sleep_mode(slp), .wake_req(wake), .domain_en(den), .async_detect_en(adet),
        .core_run(run), .amp_full_swing(amp), .xtal_range(rng));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        @(posedge mclk);
        while (ack !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        chk(ack, 1'b1, "bus ack");
        q = rd;
        req <= '0;
    endtask : wb
    task rst(input clk_sel_pkg::fuse_t f);
        @(posedge mclk);
        fuse <= f;
        rst_b <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        t = 0;
        while (run !== 1'b1 && t < 3000) begin
            @(posedge mclk);
            t++;
        end
        chk(run, 1'b1, "start-up done");
    endtask : rst
    // Window lengths are multiples of the period, so phase does not matter
    task cnt(input int n);
        pc = '{default: 0};
        repeat (n) begin
            @(posedge mclk);
            for (int b = 0; b < 5; b++) pc[b] += den[b];
        end
    endtask : cnt
    function automatic logic [2:0] src_of(input logic [3:0] c);
        if (c >= 4'ha) return 3'h0;
        if (c == 4'h9) return 3'h1;
        if (c >= 4'h5) return 3'h2;
        if (c >= 4'h1) return 3'h3;
        return 3'h4;
    endfunction : src_of
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge mclk);
        fails++;
        tally_and_finish;
    end
    initial begin
        rst(clk_sel_pkg::FUSE_SHIPPED);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0, "divider reset");
        // Range code 101 stands for a ceramic resonator, never a quartz crystal
        for (int c = 0; c < 16; c++) begin
            rst('{c[0], 2'h2, c[3:0]});
            wb(1'b0, clk_sel_pkg::REG_STATUS_OFS, 32'h0);
            chk(q[2:0], src_of(c[3:0]), "source");
            chk(q[8], 1'b1, "run bit");
            chk(amp, !c[0], "amp mode");
            if (c >= 10) chk(rng, c[0] ? c[3:1] - 5 : 3, "range");
        end
        $display("fuse decode test done");
        rst(clk_sel_pkg::FUSE_SHIPPED);
        wb(1'b0, clk_sel_pkg::REG_STATUS_OFS, 32'h0);
        chk(q[2:0], 3'h3, "shipped source");
        wb(1'b1, 8'h0c, 32'hff);
        wb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h0, "unmapped");
        wb(1'b1, 8'h00, 32'hfd);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, 32'hfd, "div write");
        cnt(140);
        cnt(40);
        chk(pc[4], 10, "core div 4");
        chk(pc[1], 10, "adc div 4");
        wb(1'b1, 8'h00, 32'h80);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, 32'hfd, "value kept");
        wb(1'b1, 8'h00, 32'h05);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h7d, "value discarded");
        cnt(140);
        cnt(40);
        chk(pc[4], 40, "core undivided");
        wb(1'b1, 8'h00, 32'hff);
        cnt(140);
        cnt(40);
        chk(pc[3], 20, "io div 2");
        $display("divider test done");
        slp <= clk_sel_pkg::SLP_IDLE;
        cnt(4);
        cnt(40);
        chk(pc[4], 0, "idle core");
        chk(pc[2], 0, "idle flash");
        chk(pc[3], 20, "idle io");
        slp <= clk_sel_pkg::SLP_ADC_NR;
        cnt(4);
        cnt(40);
        chk(pc[3], 0, "quiet io");
        chk(pc[1], 20, "quiet adc");
        slp <= clk_sel_pkg::SLP_POWER_SAVE;
        cnt(4);
        cnt(64);
        chk(pc[0] != 0, 1'b1, "async timer");
        chk(adet, 1'b1, "async sense");
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(run, 1'b0, "held on wake");
        t = 0;
        while (run !== 1'b1 && t < 3000) begin
            @(posedge mclk);
            t++;
        end
        chk(t >= 6 && t < 3000, 1'b1, "wake length");
        slp <= clk_sel_pkg::SLP_ACTIVE;
        $display("sleep and wake test done");
        tally_and_finish;
    end
endmodule : tb
